// ---- logic/nps_seq.sv ----
// program/erase sequencer for a 512-byte nonvolatile array, APB slave
// assumes a zero-wait APB master on pclk; the array cells hold their
// contents across reset and start erased
`include "nps_map.svh"

module nps_seq
    import nps_pkg::*;
(
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`NPS_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // charge pump request
    output logic                         hv_on
);

    // ****************************************************************
    // decode
    // ****************************************************************
    logic       is_arr;
    logic       is_ctrl;
    logic       is_nvcfg;
    logic       is_acr;
    logic       is_tgt;
    logic [8:0] idx;
    logic       acc_wr;
    logic       acc_rd;
    logic       setup;

    assign is_arr   = ~paddr[`NPS_ARR_SEL_BIT];
    assign is_ctrl  = paddr == `NPS_ADDR_CTRL;
    assign is_nvcfg = paddr == `NPS_ADDR_NVCFG;
    assign is_acr   = paddr == `NPS_ADDR_ACR;
    assign is_tgt   = is_arr | is_nvcfg;
    assign idx      = paddr[`NPS_IDX_HI:`NPS_IDX_LO];
    assign setup    = psel & ~penable;
    assign acc_wr   = psel & penable & pwrite;
    assign acc_rd   = psel & penable & ~pwrite;
    assign pready   = 1'b1;

    // ****************************************************************
    // state
    // ****************************************************************
    nps_state_t            state_q;
    nps_latch_t            lat_q;
    nps_mode_t             mode_q;
    logic                  auto_q;
    logic                  fail_q;
    logic [`NPS_CNT_W-1:0] cnt_q;
    logic [4:0]            acr_q;
    logic                  load_q;
    logic                  hv_q;
    logic [7:0]            nvcfg_q = `NPS_NVCFG_INIT;
    logic [7:0]            mem [`NPS_ARRAY_BYTES];
    nps_ctrl_t             wr_ctrl;
    nps_ctrl_t             rd_ctrl;
    logic                  armed;
    logic                  ctrl_ok;
    logic                  start;
    logic                  stop_sw;
    logic                  expire;
    logic                  commit;
    logic [`NPS_CNT_W-1:0] limit;
    logic                  prot_en;

    assign wr_ctrl = nps_ctrl_t'(pwdata[`NPS_CTRL_W-1:0]);
    assign armed   = (state_q == NPS_ARMED) | (state_q == NPS_LOADED);
    assign prot_en = acr_q[`NPS_ACR_PROT];
    // control writes ignored once armed, until a valid target is latched
    assign ctrl_ok = acc_wr & is_ctrl & (state_q != NPS_ARMED);
    assign start   = ctrl_ok & (state_q == NPS_LOADED)
                   & wr_ctrl.hv_enable;
    assign stop_sw = ctrl_ok & (state_q == NPS_HV) & ~wr_ctrl.hv_enable;
    assign expire  = (state_q == NPS_HV) & auto_q & (cnt_q == limit);
    assign commit  = (stop_sw | expire) & ~fail_q;
    assign hv_on   = hv_q;

    // auto delays sit below the manual times
    always_comb begin
        unique case (mode_q)
            NPS_BYTE_PGM:    limit = `NPS_CNT_W'(`NPS_CYC_AUTO_PGM);
            NPS_BYTE_ERASE:  limit = `NPS_CNT_W'(`NPS_CYC_AUTO_BYTE);
            NPS_BLOCK_ERASE: limit = `NPS_CNT_W'(`NPS_CYC_AUTO_BLOCK);
            NPS_BULK_ERASE:  limit = `NPS_CNT_W'(`NPS_CYC_AUTO_BULK);
        endcase
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= NPS_IDLE;
        end else begin
            unique case (state_q)
                NPS_IDLE: begin
                    if (ctrl_ok && wr_ctrl.latch_arm) begin
                        state_q <= NPS_ARMED;
                    end
                end
                NPS_ARMED: begin
                    if ((acc_wr || acc_rd) && is_tgt) begin
                        state_q <= NPS_LOADED;
                    end
                end
                NPS_LOADED: begin
                    if (start) begin
                        state_q <= NPS_HV;
                    end else if (ctrl_ok && !wr_ctrl.latch_arm) begin
                        state_q <= NPS_IDLE;
                    end
                end
                NPS_HV: begin
                    // arm stays set whatever the write says
                    if (stop_sw || expire) begin
                        state_q <= NPS_LOADED;
                    end
                end
            endcase
        end
    end

    // pump request from its own flop, follows the sequencer into and
    // out of the active cycle on the same edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_q <= 1'b0;
        end else if (start) begin
            hv_q <= 1'b1;
        end else if (stop_sw || expire) begin
            hv_q <= 1'b0;
        end
    end

    // mode and auto bits frozen while the pump is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= NPS_BYTE_PGM;
            auto_q <= 1'b0;
        end else if (ctrl_ok && state_q != NPS_HV) begin
            mode_q <= nps_mode_t'({wr_ctrl.mode_sel_hi,
                                   wr_ctrl.mode_sel_lo});
            auto_q <= wr_ctrl.auto_term;
        end
    end

    // address and data latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_q <= '0;
        end else if (armed && is_tgt && acc_wr) begin
            lat_q <= '{nv_cfg: is_nvcfg, idx: idx,
                       data: pwdata[7:0]};
        end else if (armed && is_tgt && acc_rd) begin
            lat_q.nv_cfg <= is_nvcfg;
            lat_q.idx    <= idx;
        end
    end

    // cycle timer and failure flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            fail_q <= 1'b0;
        end else if (start) begin
            cnt_q  <= '0;
            fail_q <= 1'b0;
        end else if (state_q == NPS_HV) begin
            if (cnt_q != limit) begin
                cnt_q <= cnt_q + 1'b1;
            end
            if (acc_rd && is_tgt) begin
                fail_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // protection image, loaded after reset and on config reads while idle
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q <= 1'b1;
            acr_q  <= `NPS_ACR_RESET;
        end else begin
            load_q <= 1'b0;
            if (load_q || (acc_rd && is_nvcfg && state_q == NPS_IDLE)) begin
                acr_q <= nvcfg_q[`NPS_ACR_PROT:0];
            end
        end
    end

    // config byte: byte modes only, locked once secured
    always_ff @(posedge pclk) begin
        if (commit && lat_q.nv_cfg && prot_en) begin
            if (mode_q == NPS_BYTE_PGM) begin
                nvcfg_q <= nvcfg_q & lat_q.data;
            end else if (mode_q == NPS_BYTE_ERASE) begin
                nvcfg_q <= `NPS_ERASED;
            end
        end
    end

    // ****************************************************************
    // array cells
    // ****************************************************************
    for (genvar g = 0; g < `NPS_ARRAY_BYTES; g++) begin : g_cell
        localparam logic [8:0] IDX = 9'(g);
        logic [7:0] cell_q = `NPS_ERASED;
        logic       blk_hit;
        logic       byte_hit;
        logic       open_b;
        logic       pgm;
        logic       ers;

        assign blk_hit  = lat_q.idx[8:`NPS_BLK_SHIFT]
                        == IDX[8:`NPS_BLK_SHIFT];
        assign byte_hit = ~lat_q.nv_cfg & (lat_q.idx == IDX);
        assign open_b   = ~acr_q[IDX[8:`NPS_BLK_SHIFT]]
                        & ~(~prot_en & IDX >= `NPS_SEC_FIRST
                            & IDX <= `NPS_SEC_LAST);
        assign pgm = commit & open_b & byte_hit & (mode_q == NPS_BYTE_PGM);
        assign ers = commit & open_b & (
                     (byte_hit & mode_q == NPS_BYTE_ERASE)
                   | (prot_en & blk_hit & ~lat_q.nv_cfg
                      & mode_q == NPS_BLOCK_ERASE)
                   | (prot_en & mode_q == NPS_BULK_ERASE));

        always_ff @(posedge pclk) begin
            if (ers) begin
                cell_q <= `NPS_ERASED;
            end else if (pgm) begin
                cell_q <= cell_q & lat_q.data;
            end
        end

        assign mem[g] = cell_q;
    end

    // ****************************************************************
    // read data, captured in the setup phase
    // ****************************************************************
    always_comb begin
        rd_ctrl             = '0;
        rd_ctrl.op_fail     = fail_q;
        rd_ctrl.auto_term   = auto_q;
        rd_ctrl.mode_sel_hi = mode_q[1];
        rd_ctrl.mode_sel_lo = mode_q[0];
        rd_ctrl.latch_arm   = state_q != NPS_IDLE;
        rd_ctrl.hv_enable   = state_q == NPS_HV;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= ~(is_tgt | is_ctrl | is_acr);
            if (is_tgt && armed) begin
                prdata <= {24'h00_0000, lat_q.data};
            end else if (is_arr) begin
                prdata <= {24'h00_0000, mem[idx]};
            end else if (is_nvcfg) begin
                prdata <= {24'h00_0000, nvcfg_q};
            end else if (is_ctrl) begin
                prdata <= {26'h000_0000, rd_ctrl};
            end else if (is_acr) begin
                prdata <= {27'h000_0000, acr_q};
            end else begin
                prdata <= '0;
            end
        end
    end

endmodule

// ---- logic/nps_map.svh ----
// constants for the nonvolatile program/erase sequencer
// assumes a 12-bit byte address on the register bus and a 125 MHz clock
`ifndef NPS_MAP_SVH
`define NPS_MAP_SVH

// ****************************************************************
// address map (byte addresses)
// ****************************************************************
`define NPS_ADDR_W      12
`define NPS_ADDR_CTRL   12'h800
`define NPS_ADDR_NVCFG  12'h804
`define NPS_ADDR_ACR    12'h808
`define NPS_ARR_SEL_BIT 11
`define NPS_IDX_HI      10
`define NPS_IDX_LO      2

// ****************************************************************
// array layout and values
// ****************************************************************
`define NPS_ARRAY_BYTES 512
`define NPS_BLK_SHIFT   7
`define NPS_SEC_FIRST   9'h0F0
`define NPS_SEC_LAST    9'h0FF
`define NPS_ERASED      8'hFF
`define NPS_NVCFG_INIT  8'hF0
`define NPS_ACR_RESET   5'h0F
`define NPS_ACR_PROT    4
`define NPS_CTRL_W      6

// ****************************************************************
// timing
// ****************************************************************
`define NPS_CLK_MHZ         125
`define NPS_T_AUTO_PGM_NS   8000
`define NPS_T_AUTO_BYTE_NS  8000
`define NPS_T_AUTO_BLOCK_NS 16000
`define NPS_T_AUTO_BULK_NS  24000
`define NPS_CYC_AUTO_PGM   ((`NPS_T_AUTO_PGM_NS * `NPS_CLK_MHZ) / 1000)
`define NPS_CYC_AUTO_BYTE  ((`NPS_T_AUTO_BYTE_NS * `NPS_CLK_MHZ) / 1000)
`define NPS_CYC_AUTO_BLOCK ((`NPS_T_AUTO_BLOCK_NS * `NPS_CLK_MHZ) / 1000)
`define NPS_CYC_AUTO_BULK  ((`NPS_T_AUTO_BULK_NS * `NPS_CLK_MHZ) / 1000)
`define NPS_CNT_W          12

`endif

// ---- logic/nps_pkg.sv ----
// types shared by the program/erase sequencer
// assumes nps_map.svh is on the include path
package nps_pkg;

    // operation selected by the two mode-select bits
    typedef enum logic [1:0] {
        NPS_BYTE_PGM,
        NPS_BYTE_ERASE,
        NPS_BLOCK_ERASE,
        NPS_BULK_ERASE
    } nps_mode_t;

    // control register image, high bit first
    typedef struct packed {
        logic op_fail;
        logic auto_term;
        logic mode_sel_hi;
        logic mode_sel_lo;
        logic latch_arm;
        logic hv_enable;
    } nps_ctrl_t;

    // address and data latch
    typedef struct packed {
        logic       nv_cfg;
        logic [8:0] idx;
        logic [7:0] data;
    } nps_latch_t;

    typedef enum logic [1:0] {
        NPS_IDLE,
        NPS_ARMED,
        NPS_LOADED,
        NPS_HV
    } nps_state_t;

endpackage

// ---- sim/nps_chk.sv ----
// assertions on the sequencer's apb and pump ports
// assumes nps_map.svh on the include path; bound onto nps_seq
`include "nps_map.svh"
module nps_chk (
    // clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`NPS_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // pump
    input wire logic                   hv_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // helpers
    // ****************
    localparam logic [11:0] AUTO_MIN = 12'(`NPS_CYC_AUTO_PGM);
    logic        unmap;
    logic        hv_set;
    logic        hv_clr;
    logic [11:0] hv_cnt_q;
    logic [11:0] hv_cnt_d;
    assign unmap = paddr[11] && paddr != `NPS_ADDR_CTRL &&
        paddr != `NPS_ADDR_NVCFG && paddr != `NPS_ADDR_ACR;
    assign hv_set = psel && penable && pwrite &&
        paddr == `NPS_ADDR_CTRL && pwdata[0];
    assign hv_clr = psel && penable && pwrite &&
        paddr == `NPS_ADDR_CTRL && !pwdata[0];
    assign hv_cnt_d = hv_on ? hv_cnt_q + 12'h001 : 12'h000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hv_cnt_q <= 12'h000;
        else
            hv_cnt_q <= hv_cnt_d;
    end
    // ****************
    // properties
    // ****************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad_setup;
        s_setup ##0 unmap;
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (s_bad_setup |=> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (s_setup ##0 !unmap |=> !pslverr)
        else $error("error on mapped address");
    a_zero_unmapped: assert property (s_bad_setup |=> prdata == '0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (s_setup |=> prdata[31:8] == '0)
        else $error("upper read bits set");
    a_rd_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    a_hv_start: assert property ($rose(hv_on) |-> $past(hv_set))
        else $error("pump on without enable write");
    a_hv_stays: assert property (
        hv_on && !hv_clr |=> hv_on || hv_cnt_q >= AUTO_MIN)
        else $error("pump dropped early");
    a_hv_fall: assert property (
        $fell(hv_on) |-> $past(hv_clr) || hv_cnt_q >= AUTO_MIN)
        else $error("pump off without cause");
endmodule

bind nps_seq nps_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .hv_on);

// ---- sim/tb.sv ----
// self-checking bench for the program/erase sequencer
// assumes nps_seq, nps_pkg and nps_map.svh compiled alongside
`include "nps_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ctl_a = `NPS_ADDR_CTRL;
    localparam logic [11:0] cfg_a = `NPS_ADDR_NVCFG;
    localparam logic [11:0] acr_a = `NPS_ADDR_ACR;
    // manual waits outlast every auto delay
    localparam int          t_program      = `NPS_CYC_AUTO_BULK + 8;
    localparam int          t_byte_erase   = `NPS_CYC_AUTO_BULK + 8;
    localparam int          t_voltage_fall = 16;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hv_on;
    int          fail_count;
    int          total_checks;

    nps_seq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .hv_on);

    always #4 pclk = ~pclk;

    // ****************
    // bus tasks
    // ****************
    function automatic logic [11:0] arr(input int i);
        return 12'(i * 4);
    endfunction
    task automatic check(input logic [31:0] g, x, input string m);
        total_checks++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, 32'(d), r, e);
    endtask
    task automatic rd_raw(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        logic [31:0] r;
        rd_raw(a, r);
        check(r, 32'(x), "read");
    endtask
    // starts the pump, optionally spoils it, polls until auto end
    task automatic fire(input logic [7:0] c, input bit spoil,
        output logic [31:0] r);
        int n;
        wr(ctl_a, c | 8'h01);
        if (spoil)
            rd_raw(arr(0), r);
        n = 0;
        do begin
            rd_raw(ctl_a, r);
            n++;
        end while (r[0] !== 1'b0 && n < 2000);
        check(r & 32'h3, 32'h2, "arm kept");
        wr(ctl_a, 8'h00);
    endtask
    task automatic op(input logic [7:0] c, input logic [11:0] a,
        input logic [7:0] d);
        logic [31:0] r;
        wr(ctl_a, c);
        wr(a, d);
        fire(c, 1'b0, r);
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_basic;
        logic [31:0] r;
        logic        e;
        rd(arr(0), 8'hFF);
        rd(arr(511), 8'hFF);
        rd(ctl_a, 8'h00);
        rd(cfg_a, 8'hF0);
        rd(acr_a, 8'h10);
        apb(1'b0, 12'h80C, 32'h0, r, e);
        check(32'(e), 32'h1, "unmapped");
    endtask
    task automatic t_prog;
        op(8'h12, arr(0), 8'hFE);
        rd(arr(0), 8'hFE);
        op(8'h12, arr(0), 8'hFD);
        rd(arr(0), 8'hFC);
        op(8'h12, arr(0), 8'hFF);
        rd(arr(0), 8'hFC);
        op(8'h16, arr(0), 8'h00);
        rd(arr(0), 8'hFF);
    endtask
    task automatic t_block;
        op(8'h12, arr(0), 8'h00);
        op(8'h12, arr(128), 8'h00);
        op(8'h12, arr(300), 8'h00);
        op(8'h1A, arr(5), 8'h55);
        rd(arr(0), 8'hFF);
        rd(arr(128), 8'h00);
        op(8'h1E, arr(200), 8'h00);
        rd(arr(128), 8'hFF);
        rd(arr(300), 8'hFF);
    endtask
    task automatic t_latch;
        logic [31:0] r;
        wr(ctl_a, 8'h01);
        rd(ctl_a, 8'h00);
        wr(ctl_a, 8'h12);
        wr(ctl_a, 8'h13);
        rd(ctl_a, 8'h12);
        wr(arr(1), 8'h0F);
        wr(arr(2), 8'hF3);
        rd(arr(9), 8'hF3);
        fire(8'h12, 1'b0, r);
        rd(arr(1), 8'hFF);
        rd(arr(2), 8'hFF);
        rd(arr(9), 8'hF3);
    endtask
    task automatic t_manual;
        wr(ctl_a, 8'h02);
        wr(arr(11), 8'h3C);
        wr(ctl_a, 8'h03);
        rd(ctl_a, 8'h03);
        check(32'(hv_on), 32'h1, "pump on");
        repeat (t_program) @(posedge pclk);
        check(32'(hv_on), 32'h1, "no timer in manual");
        wr(ctl_a, 8'h00);
        rd(ctl_a, 8'h02);
        check(32'(hv_on), 32'h0, "pump off");
        repeat (t_voltage_fall) @(posedge pclk);
        wr(ctl_a, 8'h00);
        rd(ctl_a, 8'h00);
        rd(arr(11), 8'h3C);
        wr(ctl_a, 8'h06);
        wr(arr(11), 8'h00);
        wr(ctl_a, 8'h07);
        repeat (t_byte_erase) @(posedge pclk);
        check(32'(hv_on), 32'h1, "erase pump on");
        wr(ctl_a, 8'h06);
        repeat (t_voltage_fall) @(posedge pclk);
        wr(ctl_a, 8'h00);
        rd(arr(11), 8'hFF);
    endtask
    task automatic t_fail;
        logic [31:0] r;
        wr(ctl_a, 8'h12);
        wr(arr(12), 8'h00);
        fire(8'h12, 1'b1, r);
        check(32'(r[5]), 32'h1, "fail flag");
        rd(arr(12), 8'hFF);
    endtask
    task automatic t_protect;
        op(8'h16, cfg_a, 8'h00);
        rd(cfg_a, 8'hFF);
        rd(acr_a, 8'h1F);
        op(8'h12, arr(384), 8'h00);
        rd(arr(384), 8'hFF);
        op(8'h12, cfg_a, 8'hE2);
        rd(cfg_a, 8'hE2);
        op(8'h12, arr(0), 8'h00);
        rd(arr(0), 8'h00);
        op(8'h1A, arr(0), 8'h00);
        rd(arr(0), 8'h00);
        op(8'h16, arr(0), 8'h00);
        rd(arr(0), 8'hFF);
        op(8'h12, arr(130), 8'h00);
        rd(arr(130), 8'hFF);
        op(8'h16, cfg_a, 8'h00);
        rd(cfg_a, 8'hE2);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #800_000;
        fail_count++;
        $display("unexpected at %0t: run too long", $time);
        close_out();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fail_count = 0;
        total_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_basic();
        t_prog();
        t_block();
        t_latch();
        t_manual();
        t_fail();
        t_protect();
        close_out();
    end
endmodule
